//--- inc/gpio_pkg.sv
// What this block does
// [RQ1] Pair serves as two pins or one differential
// [RQ2] Plain mode puts pad input on bit 0
// [RQ3] Double rate: rise on bit 0, fall bit 1
// [RQ4] Output bit 0; double rate adds bit 1 falling
// [RQ5] Alternate path only unregistered; HV feeds PLL only
// [RQ6] HS alternate feeds clocks, PLL, feedback, reference
// [RQ7] Output enable optionally registered on output clock
// [RQ8] Capture runs on independent input clock
// [RQ9] Deserializer: first bit 0, last bit 3
// [RQ10] Serializer sends bit 0 first, bit 3 last
// [RQ11] Core drives complement enable same as enable
// [RQ12] Delay stepping only while enable set
// [RQ13] Direction 1 steps up, 0 steps down
// [RQ14] New delay count applies about 5 ns later; code applies it one pclk cycle (50 ns) later
// [RQ15] Delay reset restores the initial count
// [RQ16] Serdes shift on their own fast clocks
// [RQ17] Sixty-four delay steps, input path only
// [RQ18] Delay count saturates at both ends
//
// Purpose: shared constants for the general purpose I/O logic
// Assumes: APB register access, one clock pclk at 20 MHz
// Notes:   all core side clocks are enable pulses derived from pclk
package gpio_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam int          APB_AW      = 8;
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_CLKDIV  = 8'h04;
   localparam logic [7:0]  OFS_TXDATA  = 8'h08;
   localparam logic [7:0]  OFS_RXDATA  = 8'h0C;
   localparam logic [7:0]  OFS_STATUS  = 8'h10;
   localparam logic [7:0]  OFS_DLYINIT = 8'h14;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
   localparam logic [31:0] CLKDIV_RST  = 32'h0000_0303;
   localparam logic [5:0]  DLYINIT_RST = 6'h00;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_IN_LSB   = 0;
   localparam int CTRL_OUT_LSB  = 2;
   localparam int CTRL_OE_REG   = 4;
   localparam int CTRL_OE       = 5;
   localparam int CTRL_DIFF     = 6;
   localparam int CTRL_HV       = 7;
   localparam int CTRL_ALT_LSB  = 8;
   localparam int CTRL_P1_OUT   = 11;
   localparam int CTRL_P1_OE    = 12;
   localparam int CTRL_DLY_EN   = 16;
   localparam int CTRL_DLY_DIR  = 17;
   localparam int CTRL_DELAY_COUNT_RESET  = 18;
   localparam int DIV_IN_LSB    = 0;
   localparam int DIV_OUT_LSB   = 8;
   localparam int DIV_SER_LSB   = 16;
   localparam int DIV_DES_LSB   = 24;
   localparam int DIV_W         = 8;
   localparam int RX_NEW        = 4;
   localparam int RX_P1         = 5;
   localparam int RX_ALT        = 6;
   localparam int ST_EMPTY      = 6;
   localparam int ST_FULL       = 7;
   localparam int ST_LVL_LSB    = 8;
   // ****************************************************************
   // Sizes and timing
   // ****************************************************************
   localparam int DATA_W        = 4;
   localparam int FIFO_DEPTH    = 8;
   localparam int DLY_STEPS     = 64;
   localparam int DLY_W         = 6;
   localparam int PCLK_NS       = 50;
   localparam int DLY_EFFECT_NS = 5;
   localparam int DLY_EFF_RAW   = DLY_EFFECT_NS / PCLK_NS;
   localparam int DLY_EFF_CYC   = (DLY_EFF_RAW < 1) ? 1 : DLY_EFF_RAW;
   // ****************************************************************
   // Modes
   // ****************************************************************
   typedef enum logic [1:0] {IN_ALT, IN_SDR, IN_DDR, IN_DESER}   in_mode_t;
   typedef enum logic [1:0] {OUT_OFF, OUT_SDR, OUT_DDR, OUT_SER} out_mode_t;
   typedef enum logic [2:0] {ALT_GLOBAL_CLOCK_FEED, ALT_RCLK, ALT_PLLREF, ALT_PLLFB, ALT_VREF} alt_sel_t;
endpackage

//--- rtl/clk_phase_gen.sv
// Purpose: rise and fall enable pulses standing in for a core clock
// Assumes: half period is half plus one pclk cycles
// Notes:   rise and fall never occur in the same cycle
`timescale 1ns/1ps
module clk_phase_gen #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         run,
   input  wire logic [W-1:0] half,
   output logic              rise,
   output logic              fall
);
   if (W < 1) begin : g_chk
      $error("clk_phase_gen width too small");
   end
   typedef struct packed {
      logic [W-1:0] cnt;
      logic         phase;
      logic         rise;
      logic         fall;
   } st_t;
   st_t s_r, s_nxt;
   always_comb begin
      s_nxt      = s_r;
      s_nxt.rise = 1'b0;
      s_nxt.fall = 1'b0;
      if (!run) begin
         s_nxt.cnt   = '0;
         s_nxt.phase = 1'b0;
      end else if (s_r.cnt >= half) begin
         s_nxt.cnt   = '0;
         s_nxt.phase = ~s_r.phase;
         s_nxt.rise  = ~s_r.phase;
         s_nxt.fall  = s_r.phase;
      end else begin
         s_nxt.cnt = s_r.cnt + W'(1);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign rise = s_r.rise;
   assign fall = s_r.fall;
endmodule

//--- rtl/general_purpose_io_logic.sv
// Purpose: core side logic of one I/O pair used as general purpose pins
// Assumes: APB slave on pclk; pads arrive asynchronously
// Notes:   pad p carries the data path; pad n is second pin or complement
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
module general_purpose_io_logic
   import gpio_pkg::*;
#(
   parameter int DW    = DATA_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [1:0]        pad_in,
   output logic [1:0]             pad_out,
   output logic [1:0]             pad_oe,
   output logic                   global_clock_feed,
   output logic                   regional_clock_feed,
   output logic                   pll_reference_feed,
   output logic                   pll_feedback_input,
   output logic                   vref_feed
);
   if (DW != DATA_W || DEPTH < 2) begin : g_chk
      $error("general_purpose_io_logic supports only four bit words");
   end
   localparam int        CW      = $clog2(DEPTH+1);
   localparam logic [DLY_W-1:0] DLY_MAX = DLY_W'(DLY_STEPS-1);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [31:0]          ctrl;
      logic [31:0]          clkdiv;
      logic [DLY_W-1:0]     dly_init;
      logic [1:0]           sync1;
      logic [1:0]           sync2;
      logic [DLY_STEPS-1:0] line;
      logic [DLY_W-1:0]     dly_cnt;
      logic [DLY_W-1:0]     dly_eff;
      logic [3:0]           eff_tmr;
      logic                 hi_bit;
      logic [DW-1:0]        rx_data;
      logic                 rx_new;
      logic [DW-1:0]        des_buf;
      logic [1:0]           des_idx;
      logic [4:0]           feeds;
      logic                 out_bit;
      logic                 ddr_lo;
      logic [DW-1:0]        ser_sh;
      logic [2:0]           ser_left;
      logic                 ser_pend;
      logic                 oe_q;
      logic [1:0]           pad_out;
      logic [1:0]           pad_oe;
      logic                 pready;
      logic [31:0]          prdata;
      logic                 pslverr;
   } st_t;
   st_t s_r, s_nxt;
   // ****************************************************************
   // Clock enables and transmit FIFO
   // ****************************************************************
   logic          in_rise, in_fall, out_rise, out_fall, ser_tick, des_tick;
   logic          fifo_in_ready, fifo_valid, pop, push;
   logic [DW-1:0] fifo_data;
   logic [CW-1:0] fifo_level;
   logic          hs;
   assign hs = ~s_r.ctrl[CTRL_HV];
   clk_phase_gen #(.W(DIV_W)) u_input_clock (                    // [RQ8]
      .pclk    (pclk),
      .presetn (presetn),
      .run     (1'b1),
      .half    (s_r.clkdiv[DIV_IN_LSB +: DIV_W]),
      .rise    (in_rise),
      .fall    (in_fall)
   );
   clk_phase_gen #(.W(DIV_W)) u_output_clock (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (1'b1),
      .half    (s_r.clkdiv[DIV_OUT_LSB +: DIV_W]),
      .rise    (out_rise),
      .fall    (out_fall)
   );
   clk_phase_gen #(.W(DIV_W)) u_serializer_clock (               // [RQ16]
      .pclk    (pclk),
      .presetn (presetn),
      .run     (hs),
      .half    (s_r.clkdiv[DIV_SER_LSB +: DIV_W]),
      .rise    (ser_tick),
      .fall    ()
   );
   clk_phase_gen #(.W(DIV_W)) u_deserializer_clock (             // [RQ16]
      .pclk    (pclk),
      .presetn (presetn),
      .run     (hs),
      .half    (s_r.clkdiv[DIV_DES_LSB +: DIV_W]),
      .rise    (des_tick),
      .fall    ()
   );
   gpio_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_tx_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (pwdata[DW-1:0]),
      .out_valid (fifo_valid),
      .out_ready (pop),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );
   // ****************************************************************
   // Next state
   // ****************************************************************
   in_mode_t  in_mode;
   out_mode_t out_mode;
   logic      access, mapped, wr_done, pad_bit, oe_now;
   logic [31:0] rd_val;
   assign access  = psel & penable;
   assign wr_done = access & s_r.pready & pwrite & ~s_r.pslverr;
   assign push    = wr_done & (paddr == OFS_TXDATA);
   assign mapped  = (paddr == OFS_CTRL)   || (paddr == OFS_CLKDIV) ||
                    (paddr == OFS_TXDATA) || (paddr == OFS_RXDATA) ||
                    (paddr == OFS_STATUS) || (paddr == OFS_DLYINIT);
   always_comb begin
      s_nxt    = s_r;
      pop      = 1'b0;
      in_mode  = in_mode_t'(s_r.ctrl[CTRL_IN_LSB +: 2]);
      out_mode = out_mode_t'(s_r.ctrl[CTRL_OUT_LSB +: 2]);
      // High voltage cell has no serdes; fall back to single rate
      if (!hs && in_mode == IN_DESER) begin
         in_mode = IN_SDR;
      end
      if (!hs && out_mode == OUT_SER) begin
         out_mode = OUT_SDR;
      end
      rd_val = '0;
      case (paddr)
         OFS_CTRL:    rd_val = s_r.ctrl;
         OFS_CLKDIV:  rd_val = s_r.clkdiv;
         OFS_RXDATA: begin
            rd_val[DW-1:0] = s_r.rx_data;
            rd_val[RX_NEW] = s_r.rx_new;
            rd_val[RX_P1]  = s_r.sync2[1];
            rd_val[RX_ALT] = |s_r.feeds;
         end
         OFS_STATUS: begin
            rd_val[DLY_W-1:0]          = s_r.dly_cnt;
            rd_val[ST_EMPTY]           = ~fifo_valid;
            rd_val[ST_FULL]            = ~fifo_in_ready;
            rd_val[ST_LVL_LSB +: CW]   = fifo_level;
         end
         OFS_DLYINIT: rd_val[DLY_W-1:0] = s_r.dly_init;
         default:     rd_val = '0;
      endcase
      // APB: one wait state; a push to a full FIFO stalls
      if (s_r.pready) begin
         s_nxt.pready  = 1'b0;
         s_nxt.pslverr = 1'b0;
      end else if (access && !(pwrite && paddr == OFS_TXDATA && !fifo_in_ready)) begin
         s_nxt.pready  = 1'b1;
         s_nxt.pslverr = ~mapped;
         s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd_val;
         if (!pwrite && paddr == OFS_RXDATA) begin
            s_nxt.rx_new = 1'b0;
         end
      end
      if (wr_done && paddr == OFS_CTRL) begin
         s_nxt.ctrl               = pwdata;
         s_nxt.ctrl[CTRL_DELAY_COUNT_RESET] = 1'b0;
      end
      if (wr_done && paddr == OFS_CLKDIV) begin
         s_nxt.clkdiv = pwdata;
      end
      if (wr_done && paddr == OFS_DLYINIT) begin
         s_nxt.dly_init = pwdata[DLY_W-1:0];
      end
      // Pad synchroniser and delay line
      s_nxt.sync1 = pad_in;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.line  = {s_r.line[DLY_STEPS-2:0], s_r.sync2[0]};
      // Dynamic delay, stepped on the input clock, input path only
      if (wr_done && paddr == OFS_CTRL && pwdata[CTRL_DELAY_COUNT_RESET]) begin
         s_nxt.dly_cnt = s_r.dly_init;                             // [RQ15]
      end else if (hs && in_rise && s_r.ctrl[CTRL_DLY_EN]) begin   // [RQ12]
         if (s_r.ctrl[CTRL_DLY_DIR]) begin                         // [RQ13]
            if (s_r.dly_cnt != DLY_MAX) begin                      // [RQ18]
               s_nxt.dly_cnt = s_r.dly_cnt + DLY_W'(1);
            end
         end else if (s_r.dly_cnt != '0) begin                     // [RQ18]
            s_nxt.dly_cnt = s_r.dly_cnt - DLY_W'(1);
         end
      end
      if (s_r.dly_cnt == s_r.dly_eff) begin
         s_nxt.eff_tmr = '0;
      end else if (s_r.eff_tmr == 4'(DLY_EFF_CYC-1)) begin
         s_nxt.dly_eff = s_r.dly_cnt;                              // [RQ14]
         s_nxt.eff_tmr = '0;
      end else begin
         s_nxt.eff_tmr = s_r.eff_tmr + 4'(1);
      end
      // 64 tap line; the high voltage cell bypasses it
      pad_bit = hs ? s_r.line[s_r.dly_eff] : s_r.sync2[0];         // [RQ17]
      // Input capture
      s_nxt.feeds = '0;
      case (in_mode)
         IN_ALT: begin
            if (!hs) begin
               s_nxt.feeds[ALT_PLLREF] = s_r.sync2[0];             // [RQ5]
            end else begin
               case (alt_sel_t'(s_r.ctrl[CTRL_ALT_LSB +: 3]))      // [RQ6]
                  ALT_GLOBAL_CLOCK_FEED:   s_nxt.feeds[ALT_GLOBAL_CLOCK_FEED]   = s_r.sync2[0];
                  ALT_RCLK:   s_nxt.feeds[ALT_RCLK]   = s_r.sync2[0];
                  ALT_PLLREF: s_nxt.feeds[ALT_PLLREF] = s_r.sync2[0];
                  ALT_PLLFB:  s_nxt.feeds[ALT_PLLFB]  = s_r.sync2[0];
                  ALT_VREF:   s_nxt.feeds[ALT_VREF]   = s_r.sync2[0];
                  default:    s_nxt.feeds = '0;
               endcase
            end
         end
         IN_SDR: begin
            if (in_rise) begin
               s_nxt.rx_data = {{(DW-1){1'b0}}, pad_bit};          // [RQ2]
               s_nxt.rx_new  = 1'b1;
            end
         end
         IN_DDR: begin
            if (in_rise) begin
               s_nxt.hi_bit = pad_bit;
            end
            if (in_fall) begin
               s_nxt.rx_data = {2'b00, pad_bit, s_r.hi_bit};       // [RQ3]
               s_nxt.rx_new  = 1'b1;
            end
         end
         IN_DESER: begin
            if (des_tick) begin
               s_nxt.des_buf[s_r.des_idx] = pad_bit;               // [RQ9]
               s_nxt.des_idx = s_r.des_idx + 2'(1);
               if (s_r.des_idx == 2'(DW-1)) begin
                  s_nxt.rx_data = s_nxt.des_buf;
                  s_nxt.rx_new  = 1'b1;
               end
            end
         end
         default: s_nxt.feeds = '0;
      endcase
      // Output path on the output clock; the serializer shifts on its own clock
      case (out_mode)
         OUT_SDR: begin
            if (out_rise && fifo_valid) begin
               pop           = 1'b1;
               s_nxt.out_bit = fifo_data[0];                       // [RQ4]
            end
         end
         OUT_DDR: begin
            if (out_rise && fifo_valid) begin
               pop           = 1'b1;
               s_nxt.out_bit = fifo_data[0];                       // [RQ4]
               s_nxt.ddr_lo  = fifo_data[1];
            end
            if (out_fall) begin
               s_nxt.out_bit = s_r.ddr_lo;                         // [RQ4]
            end
         end
         OUT_SER: begin
            if (out_rise) begin
               s_nxt.ser_pend = 1'b1;
            end
            if (ser_tick && s_r.ser_left != '0) begin
               s_nxt.out_bit  = s_r.ser_sh[0];                     // [RQ10]
               s_nxt.ser_sh   = s_r.ser_sh >> 1;
               s_nxt.ser_left = s_r.ser_left - 3'(1);
            end else if (ser_tick && s_r.ser_pend && fifo_valid) begin
               pop            = 1'b1;
               s_nxt.ser_pend = 1'b0;
               s_nxt.out_bit  = fifo_data[0];                      // [RQ10]
               s_nxt.ser_sh   = fifo_data >> 1;
               s_nxt.ser_left = 3'(DW-1);
            end
         end
         default: s_nxt.ser_pend = 1'b0;
      endcase
      // Registered enable waits for the output clock
      if (!s_r.ctrl[CTRL_OE_REG]) begin
         s_nxt.oe_q = s_r.ctrl[CTRL_OE];                           // [RQ7]
      end else if (out_rise) begin
         s_nxt.oe_q = s_r.ctrl[CTRL_OE];                           // [RQ7]
      end
      oe_now           = s_nxt.oe_q & (out_mode != OUT_OFF);
      s_nxt.pad_out[0] = s_nxt.out_bit;
      s_nxt.pad_oe[0]  = oe_now;
      if (!hs) begin
         s_nxt.pad_out[1] = 1'b0;
         s_nxt.pad_oe[1]  = 1'b0;
      end else if (s_r.ctrl[CTRL_DIFF]) begin                      // [RQ1]
         s_nxt.pad_out[1] = ~s_nxt.out_bit;
         s_nxt.pad_oe[1]  = oe_now;                                // [RQ11]
      end else begin                                               // [RQ1]
         s_nxt.pad_out[1] = s_r.ctrl[CTRL_P1_OUT];
         s_nxt.pad_oe[1]  = s_r.ctrl[CTRL_P1_OE];
      end
   end
   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r          <= '0;
         s_r.ctrl     <= CTRL_RST;
         s_r.clkdiv   <= CLKDIV_RST;
         s_r.dly_init <= DLYINIT_RST;
         s_r.dly_cnt  <= DLYINIT_RST;
         s_r.dly_eff  <= DLYINIT_RST;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign prdata              = s_r.prdata;
   assign pready              = s_r.pready;
   assign pslverr             = s_r.pslverr;
   assign pad_out             = s_r.pad_out;
   assign pad_oe              = s_r.pad_oe;
   assign global_clock_feed   = s_r.feeds[ALT_GLOBAL_CLOCK_FEED];
   assign regional_clock_feed = s_r.feeds[ALT_RCLK];
   assign pll_reference_feed  = s_r.feeds[ALT_PLLREF];
   assign pll_feedback_input  = s_r.feeds[ALT_PLLFB];
   assign vref_feed           = s_r.feeds[ALT_VREF];
endmodule

//--- rtl/gpio_fifo.sv
// Purpose: small flip-flop FIFO in the transmit data path
// Assumes: push and pop follow valid and ready handshakes
// Notes:   head word is visible whenever out_valid is high
`timescale 1ns/1ps
module gpio_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 8
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH+1);
   if (DEPTH < 2 || WIDTH < 1) begin : g_chk
      $error("gpio_fifo needs depth of two or more");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wp;
      logic [PW-1:0]               rp;
      logic [CW-1:0]               cnt;
   } st_t;
   st_t  s_r, s_nxt;
   logic push;
   logic pop;
   assign in_ready  = (s_r.cnt != CW'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = s_r.mem[s_r.rp];
   assign level     = s_r.cnt;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = (s_r.wp == PW'(DEPTH-1)) ? '0 : s_r.wp + PW'(1);
      end
      if (pop) begin
         s_nxt.rp = (s_r.rp == PW'(DEPTH-1)) ? '0 : s_r.rp + PW'(1);
      end
      if (push && !pop) begin
         s_nxt.cnt = s_r.cnt + CW'(1);
      end else if (pop && !push) begin
         s_nxt.cnt = s_r.cnt - CW'(1);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

//--- verification/gpio_asserts.sv
// Purpose: port level checks of the I/O logic
// Assumes: CTRL writes are seen on the APB pins
// Notes:   feed and pair checks wait 4 cycles after a CTRL write
`timescale 1ns/1ps
module gpio_asserts
   import gpio_pkg::*;
(
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [1:0]        pad_out,
   input wire logic [1:0]        pad_oe,
   input wire logic              global_clock_feed,
   input wire logic              regional_clock_feed,
   input wire logic              pll_reference_feed,
   input wire logic              pll_feedback_input,
   input wire logic              vref_feed
);
   // ****
   // Shadow of CTRL
   // ****
   logic [31:0] ctrl_r;
   logic [2:0]  age_r;
   logic        ok;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         age_r  <= 3'h0;
      end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
         ctrl_r <= pwdata;
         age_r  <= 3'h0;
      end else if (age_r != 3'h7) begin
         age_r <= age_r + 3'h1;
      end
   end
   // Settled once the new mode has passed the pad sync
   assign ok = age_r > 3'h3;
   // ****
   // Properties
   // ****
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable;
   endsequence
   a_one_wait: assert property (s_setup ##1 s_access |-> !pready) else $error("no wait state");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
   a_err_unmapped: assert property (pready && (paddr > OFS_DLYINIT || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("unmapped accepted");
   a_err_mapped: assert property (pready && paddr <= OFS_DLYINIT && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped refused");
   a_diff_pair: assert property (ok && ctrl_r[6] && !ctrl_r[7] |-> pad_out[1] == !pad_out[0]
      && pad_oe[1] == pad_oe[0]) else $error("pair mismatch");
   a_global_clock_feed_sel: assert property (ok && global_clock_feed |-> ctrl_r[1:0] == 2'h0
      && !ctrl_r[7] && ctrl_r[10:8] == 3'h0) else $error("global_clock_feed feed");
   a_hv_pll_only: assert property (ok && ctrl_r[7] |-> !global_clock_feed
      && !regional_clock_feed && !pll_feedback_input && !vref_feed)
      else $error("hv feed");
endmodule
bind general_purpose_io_logic gpio_asserts chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .pslverr(pslverr), .pad_out(pad_out), .pad_oe(pad_oe),
   .global_clock_feed(global_clock_feed), .regional_clock_feed(regional_clock_feed),
   .pll_reference_feed(pll_reference_feed), .pll_feedback_input(pll_feedback_input),
   .vref_feed(vref_feed));

//--- verification/pad_model.sv
// Purpose: pad wires seen by both pins of the pair
// Assumes: outside driver only while the pin is not driven
// Notes:   a driven pin reads back its own level
`timescale 1ns/1ps
module pad_model (
   input  wire logic [1:0] pad_out,
   input  wire logic [1:0] pad_oe,
   input  wire logic [1:0] ext,
   output logic [1:0]      pad_in
);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule

//--- verification/testbench.sv
// Purpose: directed APB tests of the I/O logic
// Assumes: internal clocks use the reset dividers
// Notes:   pad levels are static, so each mode sees all ones or zeros
`timescale 1ns/1ps
module testbench
   import gpio_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q, mk;
   logic [1:0]  pad_in, pad_out, pad_oe, ext;
   logic [4:0]  feeds;
   int          miscompares, cmp_count, cyc;
   always #25 pclk = ~pclk;
   general_purpose_io_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .global_clock_feed(feeds[4]), .regional_clock_feed(feeds[3]),
      .pll_reference_feed(feeds[2]), .pll_feedback_input(feeds[1]), .vref_feed(feeds[0]));
   pad_model pad_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext(ext), .pad_in(pad_in));
   // ****
   // Tasks
   // ****
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s exp %h got %h", n, exp, got);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000);
      chk("rd", q & m, x);
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Cuts a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   // ****
   // Sequence
   // ****
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, ext} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd(OFS_CTRL, 32'hFFFF_FFFF, CTRL_RST);
      rd(OFS_CLKDIV, 32'hFFFF_FFFF, CLKDIV_RST);
      rd(OFS_STATUS, 32'h0000_0FFF, 32'h0000_0040);
      xfer(1'b0, 8'h18, 32'h0000_0000);
      chk("err", {31'h0000_0000, e}, 32'h0000_0001);
      for (int m = 1; m < 4; m++) begin
         for (int v = 0; v < 2; v++) begin
            ext <= {1'b0, v[0]};
            xfer(1'b1, OFS_CTRL, 32'(m));
            repeat (60) @(posedge pclk);
            mk = (32'h0000_0001 << (1 << (m - 1))) - 32'h0000_0001;
            rd(OFS_RXDATA, mk | 32'h0000_0070, (v ? mk : 32'h0000_0000) | 32'h0000_0010);
         end
      end
      for (int s = 0; s < 6; s++) begin
         xfer(1'b1, OFS_CTRL, (s == 5) ? 32'h0000_0080 : 32'(s) << 8);
         repeat (8) @(posedge pclk);
         chk("feed", {27'h000_0000, feeds}, (s == 5) ? 32'h0000_0004 : 32'h0000_0010 >> s);
      end
      xfer(1'b1, OFS_DLYINIT, 32'h0000_003E);
      xfer(1'b1, OFS_CTRL, 32'h0004_0001);
      xfer(1'b1, OFS_CTRL, 32'h0002_0001);
      repeat (50) @(posedge pclk);
      rd(OFS_STATUS, 32'h0000_003F, 32'h0000_003E);
      xfer(1'b1, OFS_CTRL, 32'h0003_0001);
      repeat (100) @(posedge pclk);
      rd(OFS_STATUS, 32'h0000_003F, 32'h0000_003F);
      xfer(1'b1, OFS_CTRL, 32'h0001_0001);
      repeat (700) @(posedge pclk);
      rd(OFS_STATUS, 32'h0000_003F, 32'h0000_0000);
      xfer(1'b1, OFS_CTRL, 32'h0000_0000);
      for (int i = 0; i < 8; i++) xfer(1'b1, OFS_TXDATA, 32'(i));
      rd(OFS_STATUS, 32'h0000_0FC0, 32'h0000_0880);
      xfer(1'b1, OFS_CTRL, 32'h0000_0024);
      repeat (200) @(posedge pclk);
      rd(OFS_STATUS, 32'h0000_0FC0, 32'h0000_0040);
      chk("pad", {28'h000_0000, pad_oe, pad_out}, 32'h0000_0005);
      xfer(1'b1, OFS_CTRL, 32'h0000_0064);
      repeat (10) @(posedge pclk);
      chk("pair", {28'h000_0000, pad_oe, pad_out}, 32'h0000_000D);
      tally_and_finish();
   end
endmodule
